// file: hdl/iorb_top.sv
// The placing of the registers and the plain strobed port were decided locally.
`timescale 1ns/1ps
module iorb_top
  import iorb_pkg::*;
#(
  parameter logic [7:0] FAMILY_CODE = 8'h5a, // arbitrary value
  parameter logic [7:0] PART_CODE = 8'h01, // arbitrary value
  parameter logic [3:0] REV_CODE = 4'h1, // arbitrary value
  parameter int OST_CYC = 1024,
  parameter int POWER_UP_TIMER_CYC = 2048,
  parameter int FSCM_CYC = 512
) (
  input wire logic clk,
  input wire logic rstn,
  input wire iorb_bus_t bus,
  output logic [23:0] rdata,
  input wire logic brownout_pin,
  input wire logic pll_lock_pin,
  input wire iorb_cfg_t cfg,
  input wire logic otp_erase,
  output logic dev_reset_n,
  output logic sysclk_hold,
  output logic regulator_low_power_enable,
  output logic [1:0] regulator_one_level,
  output logic [1:0] regulator_two_level,
  output logic [1:0] regulator_three_level,
  output logic irq
);
  // ************************************************************
  // input synchronisers
  // ************************************************************
  logic [1:0] bor_sync_ff;
  logic [1:0] lock_sync_ff;
  // first stage only feeds the second
  always_ff @(posedge clk) begin
    if (!rstn) begin
      bor_sync_ff <= 2'h0;
      lock_sync_ff <= 2'h0;
    end else begin
      bor_sync_ff <= {bor_sync_ff[0], brownout_pin};
      lock_sync_ff <= {lock_sync_ff[0], pll_lock_pin};
    end
  end
  wire bor_s = bor_sync_ff[1];
  wire lock_s = lock_sync_ff[1];

  // ************************************************************
  // brown-out sequencer
  // ************************************************************
  iorb_state_t state_ff, nxt_state;
  logic [15:0] ost_cnt_ff;
  logic [15:0] power_up_timer_cnt_ff;
  logic bor_flag_ff;
  logic dev_reset_n_ff;
  logic hold_ff;
  wire ost_done = (ost_cnt_ff == 16'h0);
  wire power_up_timer_done = (power_up_timer_cnt_ff == 16'h0);
  // clock released when ost expired (osc mode) and pll locked (pll mode)
  wire clk_ok = (!cfg.osc_mode || ost_done) && (!cfg.pll_used || lock_s);

  // state register; brown-out always wins, including sleep and idle
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      IORB_RUN: if (bor_s) nxt_state = IORB_PULSE;
      IORB_PULSE: if (!bor_s && power_up_timer_cnt_ff != 16'h0) nxt_state = IORB_HOLD;
      IORB_HOLD: if (bor_s) nxt_state = IORB_PULSE;
        else if (clk_ok && power_up_timer_done) nxt_state = IORB_RUN;
      default: nxt_state = IORB_RUN;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) state_ff <= IORB_RUN;
    else state_ff <= nxt_state;
  end

  // delay counters reload during the reset pulse
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ost_cnt_ff <= 16'h0;
      power_up_timer_cnt_ff <= 16'h0;
    end else if (nxt_state == IORB_PULSE) begin
      ost_cnt_ff <= 16'(OST_CYC);
      // zero power-up delay with crystal falls back to fail-safe delay
      power_up_timer_cnt_ff <= (POWER_UP_TIMER_CYC == 0 && cfg.crystal) ? 16'(FSCM_CYC) :
                     16'((POWER_UP_TIMER_CYC == 0) ? 1 : POWER_UP_TIMER_CYC);
    end else if (state_ff == IORB_HOLD) begin
      if (!ost_done) ost_cnt_ff <= ost_cnt_ff - 16'h1;
      if (!power_up_timer_done) power_up_timer_cnt_ff <= power_up_timer_cnt_ff - 16'h1;
    end
  end

  // reset output and clock hold run in parallel
  always_ff @(posedge clk) begin
    if (!rstn) begin
      dev_reset_n_ff <= 1'b1;
      hold_ff <= 1'b0;
    end else begin
      dev_reset_n_ff <= (nxt_state == IORB_RUN);
      hold_ff <= (nxt_state != IORB_RUN) && !(nxt_state == IORB_HOLD && clk_ok);
    end
  end
  assign dev_reset_n = dev_reset_n_ff;
  assign sysclk_hold = hold_ff;

  // ************************************************************
  // register bus decode
  // ************************************************************
  wire wr_vreg = bus.wr && bus.addr == IORB_OFF_VREG;
  wire wr_reset_control_register = bus.wr && bus.addr == IORB_OFF_RESET_CONTROL_REGISTER;
  wire wr_mask = bus.wr && bus.addr == IORB_OFF_IMASK;
  wire rd_stat = bus.rd && bus.addr == IORB_OFF_ISTAT;
  wire bor_evt = (state_ff != IORB_PULSE) && (nxt_state == IORB_PULSE);

  // regulator control; fields held independently
  logic [15:0] vreg_ff;
  always_ff @(posedge clk) begin
    if (!rstn) vreg_ff <= IORB_VREG_RST;
    else if (wr_vreg) vreg_ff <= bus.wdata[15:0] & IORB_VREG_MASK;
  end

  logic lpwr_ff;
  logic [5:0] lvl_ff;
  // outputs registered straight from the control register
  always_ff @(posedge clk) begin
    if (!rstn) begin
      lpwr_ff <= 1'b0;
      lvl_ff <= 6'h0;
    end else begin
      lpwr_ff <= vreg_ff[IORB_LPWR_BIT];
      lvl_ff <= vreg_ff[5:0];
    end
  end
  assign regulator_low_power_enable = lpwr_ff;
  assign regulator_three_level = lvl_ff[5:4];
  assign regulator_two_level = lvl_ff[3:2];
  assign regulator_one_level = lvl_ff[1:0];

  // brown-out status flag: set beats software clear
  always_ff @(posedge clk) begin
    if (!rstn) bor_flag_ff <= 1'b0;
    else if (bor_evt) bor_flag_ff <= 1'b1;
    else if (wr_reset_control_register && !bus.wdata[IORB_BOR_FLAG_BIT]) bor_flag_ff <= 1'b0;
  end

  // ************************************************************
  // write-once memory
  // ************************************************************
  logic [47:0] otp_mem_ff [IORB_OTP_WORDS];
  logic [IORB_OTP_WORDS-1:0] otp_used_ff;
  logic [47:0] otp_stage_ff;
  logic [5:0] otp_idx_ff;
  wire otp_hit = bus.addr[23:8] == IORB_OTP_BASE[23:8] && bus.addr[1:0] == 2'h0;
  wire [5:0] otp_idx = bus.addr[7:2];
  // upper 24 bits staged via command register, lower 24 written at the word
  wire otp_prog = bus.wr && otp_hit;
  wire otp_err = otp_prog && otp_used_ff[otp_idx];
  wire wr_stage = bus.wr && bus.addr == IORB_OFF_OTPCMD;

  always_ff @(posedge clk) begin
    if (!rstn) otp_stage_ff <= 48'h0;
    else if (wr_stage) otp_stage_ff <= {bus.wdata, 24'h0};
  end

  // erase input is deliberately not used by this storage
  always_ff @(posedge clk) begin
    if (!rstn) otp_used_ff <= '0;
    else if (otp_prog) otp_used_ff[otp_idx] <= 1'b1;
  end

  always_ff @(posedge clk) begin
    if (otp_prog && !otp_used_ff[otp_idx])
      otp_mem_ff[otp_idx] <= {otp_stage_ff[47:24], bus.wdata};
  end

  // ************************************************************
  // interrupts
  // ************************************************************
  logic [2:0] istat_ff;
  logic [2:0] imask_ff;
  logic irq_ff;
  logic [2:0] evt;
  always_comb begin
    evt = 3'h0;
    evt[IORB_IRQ_BOR] = bor_evt;
    evt[IORB_IRQ_OTPERR] = otp_err;
    evt[IORB_IRQ_OTPDONE] = otp_prog && !otp_err;
  end
  // a read clears, but a same-cycle event survives
  always_ff @(posedge clk) begin
    if (!rstn) istat_ff <= 3'h0;
    else istat_ff <= (rd_stat ? 3'h0 : istat_ff) | evt;
  end
  always_ff @(posedge clk) begin
    if (!rstn) imask_ff <= 3'h0;
    else if (wr_mask) imask_ff <= bus.wdata[2:0];
  end
  always_ff @(posedge clk) begin
    if (!rstn) irq_ff <= 1'b0;
    else irq_ff <= |(((rd_stat ? 3'h0 : istat_ff) | evt) & imask_ff);
  end
  assign irq = irq_ff;

  // ************************************************************
  // read mux; id registers are constants, writes ignored
  // ************************************************************
  logic [23:0] rdata_ff;
  always_ff @(posedge clk) begin
    if (!rstn) rdata_ff <= 24'h0;
    else if (!bus.rd) rdata_ff <= 24'h0;
    else if (otp_hit) rdata_ff <= otp_mem_ff[otp_idx][23:0];
    else case (bus.addr)
      IORB_OFF_REV: rdata_ff <= IORB_REV_ONES | {20'h0, REV_CODE};
      IORB_OFF_PID: rdata_ff <= IORB_PID_ONES | {8'h0, FAMILY_CODE, PART_CODE};
      IORB_OFF_VREG: rdata_ff <= {8'h0, vreg_ff};
      IORB_OFF_RESET_CONTROL_REGISTER: rdata_ff <= {22'h0, bor_flag_ff, 1'b0};
      IORB_OFF_ISTAT: rdata_ff <= {21'h0, istat_ff};
      IORB_OFF_IMASK: rdata_ff <= {21'h0, imask_ff};
      IORB_OFF_OTPCMD: rdata_ff <= otp_stage_ff[47:24];
      default: rdata_ff <= 24'h0;
    endcase
  end
  assign rdata = rdata_ff;

  // ************************************************************
  // checks
  // ************************************************************
  a_bor_flag_set: assert property (@(posedge clk) disable iff (!rstn)
    bor_evt |=> bor_flag_ff) else $error("bor flag not set");
  a_reset_on_bor: assert property (@(posedge clk) disable iff (!rstn)
    bor_evt |=> !dev_reset_n) else $error("no reset on brownout");
  a_hold_lock: assert property (@(posedge clk) disable iff (!rstn)
    (state_ff == IORB_HOLD && cfg.pll_used && !lock_s) |=> sysclk_hold) else $error("clock released unlocked");
  a_hold_ost: assert property (@(posedge clk) disable iff (!rstn)
    (state_ff == IORB_HOLD && cfg.osc_mode && !ost_done) |=> sysclk_hold) else $error("clock released early");
  a_power_up_timer_gate: assert property (@(posedge clk) disable iff (!rstn)
    (state_ff == IORB_HOLD && !power_up_timer_done) |=> !dev_reset_n) else $error("reset released early");
  a_otp_once: assert property (@(posedge clk) disable iff (!rstn)
    otp_err |=> otp_mem_ff[$past(otp_idx)] == $past(otp_mem_ff[otp_idx])) else $error("otp rewritten");
  a_rev_ones: assert property (@(posedge clk) disable iff (!rstn)
    (bus.rd && bus.addr == IORB_OFF_REV) |=> rdata[IORB_REV_ONES_HI:4] == 20'hff7ff) else $error("rev pad bits");
  a_lvl_follow: assert property (@(posedge clk) disable iff (!rstn)
    wr_vreg |-> ##2 regulator_two_level == $past(bus.wdata[3:2], 2)) else $error("level not applied");
  a_sleep_bor: assert property (@(posedge clk) disable iff (!rstn)
    (bor_s && state_ff == IORB_RUN) |=> state_ff == IORB_PULSE) else $error("brownout missed");
  c_bor_seq: cover property (@(posedge clk) disable iff (!rstn) bor_evt ##[1:300] dev_reset_n);
  c_otp_twice: cover property (@(posedge clk) disable iff (!rstn) otp_err);
  c_irq: cover property (@(posedge clk) disable iff (!rstn) irq && rd_stat);
endmodule // iorb_top

// file: hdl/iorb_pkg.sv
// What this block does
// - two identification registers, both read-only to software
// - revision code bits 3-0; bits 23-16, 14-4 read one; bit 15 zero
// - family code bits 15-8, part code bits 7-0, bits 23-16 read one
// - 64 write-once 48-bit words starting at 801700h
// - no erase clears or alters the write-once words
// - low-power enable bit 15 selects low-power, clear selects full power
// - three 2-bit level fields at 5-4, 3-2, 1-0 select output level
// - each regulator level is set independently
// - brown-out issues whole-device reset and picks configured clock source
// - oscillator mode: brown-out starts start-up timer, clock held till expiry
// - pll in use: clock held until pll lock reads one
// - power-up delay applied before reset release; zero with crystal uses fail-safe delay
// - brown-out sets status flag bit 1 of reset control register
// - brown-out monitoring stays active in sleep and idle
package iorb_pkg;
  // ************************************************************
  // register map (word offsets, byte address = offset)
  // ************************************************************
  localparam logic [23:0] IORB_OFF_REV = 24'h000000;
  localparam logic [23:0] IORB_OFF_PID = 24'h000004;
  localparam logic [23:0] IORB_OFF_VREG = 24'h000008;
  localparam logic [23:0] IORB_OFF_RESET_CONTROL_REGISTER = 24'h00000c;
  localparam logic [23:0] IORB_OFF_ISTAT = 24'h000010;
  localparam logic [23:0] IORB_OFF_IMASK = 24'h000014;
  localparam logic [23:0] IORB_OFF_OTPCMD = 24'h000018;
  localparam logic [23:0] IORB_OTP_BASE = 24'h801700;
  localparam int IORB_OTP_WORDS = 64;
  // ************************************************************
  // field positions and reset values
  // ************************************************************
  localparam int IORB_LPWR_BIT = 15;
  localparam int IORB_BOR_FLAG_BIT = 1;
  localparam int IORB_REV_ONES_HI = 23;
  localparam logic [23:0] IORB_REV_ONES = 24'hff7ff0;
  localparam logic [23:0] IORB_PID_ONES = 24'hff0000;
  localparam logic [15:0] IORB_VREG_RST = 16'h0000;
  localparam logic [15:0] IORB_VREG_MASK = 16'h803f;
  localparam logic [1:0] IORB_LVL_15 = 2'h3;
  localparam logic [1:0] IORB_LVL_125 = 2'h2;
  localparam logic [1:0] IORB_LVL_10 = 2'h1;
  localparam logic [1:0] IORB_LVL_15B = 2'h0;
  // ************************************************************
  // timing (cycles at 125 MHz, defaults)
  // ************************************************************
  localparam int IORB_CLK_MHZ = 125;
  localparam int IORB_RST_PULSE_NS = 64;
  localparam int IORB_RST_PULSE_CYC = (IORB_RST_PULSE_NS * IORB_CLK_MHZ + 999) / 1000;
  // interrupt sources
  localparam int IORB_IRQ_BOR = 0;
  localparam int IORB_IRQ_OTPERR = 1;
  localparam int IORB_IRQ_OTPDONE = 2;
  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [4:0] {
    IORB_RUN = 5'h01,
    IORB_PULSE = 5'h02,
    IORB_HOLD = 5'h04,
    IORB_WAITREL = 5'h08,
    IORB_DONE = 5'h10
  } iorb_state_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [23:0] addr;
    logic [23:0] wdata;
  } iorb_bus_t;
  typedef struct packed {
    logic osc_mode;
    logic pll_used;
    logic crystal;
  } iorb_cfg_t;
endpackage : iorb_pkg

// file: tb/tb.sv
`timescale 1ns/1ps
// ************************************************************
// bench for the id, write-once store, regulator and brown-out block
// ************************************************************
module tb;
  import iorb_pkg::*;
  localparam logic [7:0] FAM = 8'h3c; // arbitrary value
  localparam logic [7:0] PRT = 8'h07; // arbitrary value
  localparam logic [3:0] REV = 4'h9; // arbitrary value
  localparam int POWER_UP_TIMER = 6; // short power-up count keeps the run brief
  logic clk;
  logic rstn;
  iorb_bus_t bus;
  iorb_cfg_t cfg;
  logic brownout_pin;
  logic pll_lock_pin;
  logic otp_erase;
  logic [23:0] rdata;
  logic dev_reset_n;
  logic sysclk_hold;
  logic lp;
  logic [1:0] l1;
  logic [1:0] l2;
  logic [1:0] l3;
  logic irq;
  int error_cnt;
  int cmp_count;
  int n;
  logic [23:0] d;
  logic [1:0] a;
  logic b0;

  iorb_top #(.FAMILY_CODE(FAM), .PART_CODE(PRT), .REV_CODE(REV), .OST_CYC(4), .POWER_UP_TIMER_CYC(POWER_UP_TIMER), .FSCM_CYC(4)) i_dut (
    .clk(clk), .rstn(rstn), .bus(bus), .rdata(rdata), .brownout_pin(brownout_pin), .pll_lock_pin(pll_lock_pin),
    .cfg(cfg), .otp_erase(otp_erase), .dev_reset_n(dev_reset_n), .sysclk_hold(sysclk_hold),
    .regulator_low_power_enable(lp), .regulator_one_level(l1), .regulator_two_level(l2),
    .regulator_three_level(l3), .irq(irq));

  // 125 mhz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // strobe drops one edge later, so a following call never collides with it
  task automatic wr(input logic [23:0] adr, input logic [23:0] v);
    @(posedge clk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: adr, wdata: v};
    @(posedge clk);
    bus <= '0;
  endtask

  // data stands only in the cycle after the strobe, sampled just past that edge
  task automatic rd(input logic [23:0] adr, output logic [23:0] v);
    @(posedge clk);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: adr, wdata: 24'h000000};
    @(posedge clk);
    bus <= '0;
    #1 v = rdata;
  endtask

  task automatic rchk(input logic [23:0] adr, input logic [23:0] exp, input string what);
    logic [23:0] v;
    rd(adr, v);
    chk(what, exp, v);
  endtask

  // bounded wait on a reset-sequencer output; running out ends the run
  task automatic wait_sig(input bit sel, input logic v, input int lim, output int cnt);
    cnt = 0;
    while ((sel ? sysclk_hold : dev_reset_n) !== v && cnt <= lim) begin
      @(posedge clk);
      #1 cnt++;
    end
    if (cnt > lim) begin
      error_cnt++;
      $display("Error wait on sequencer output expected %h seen %h", v, sel ? sysclk_hold : dev_reset_n);
      stop_test();
    end
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    rstn = 1'b0;
    bus = '0;
    cfg = '{osc_mode: 1'b1, pll_used: 1'b1, crystal: 1'b1};
    brownout_pin = 1'b0;
    pll_lock_pin = 1'b0;
    otp_erase = 1'b0;
    error_cnt = 0;
    cmp_count = 0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    // second pass proves that writes leave both id words alone
    for (n = 0; n < 2; n++) begin
      rchk(IORB_OFF_REV, {8'hff, 1'b0, 11'h7ff, REV}, "revision");
      rchk(IORB_OFF_PID, {8'hff, FAM, PRT}, "part id");
      wr(IORB_OFF_REV, 24'h000000);
      wr(IORB_OFF_PID, 24'h000000);
    end
    rchk(24'h000040, 24'h000000, "unmapped read");
    $display("test identification done");
    // every level code on each regulator, neighbours on different codes
    for (n = 0; n < 4; n++) begin
      a = n[1:0];
      // bench core is idle with no peripherals running whenever low power is set
      wr(IORB_OFF_VREG, {8'h00, n[0], 9'h000, 2'(a + 2'h2), 2'(a + 2'h1), a});
      @(posedge clk);
      #1 chk("low power", {23'h0, n[0]}, {23'h0, lp});
      chk("level one", {22'h0, a}, {22'h0, l1});
      chk("level two", {22'h0, 2'(a + 2'h1)}, {22'h0, l2});
      chk("level three", {22'h0, 2'(a + 2'h2)}, {22'h0, l3});
      rd(IORB_OFF_VREG, d);
      chk("regulator readback", {8'h00, n[0], 9'h000, 2'(a + 2'h2), 2'(a + 2'h1), a}, d & 24'h00803f);
    end
    $display("test regulator done");
    // first and last write-once words, then a rewrite and an erase
    wr(IORB_OFF_OTPCMD, 24'h0000ab);
    wr(IORB_OTP_BASE, 24'h123456);
    rchk(IORB_OTP_BASE, 24'h123456, "store word 0");
    wr(IORB_OTP_BASE + 24'h0000fc, 24'h00a5c3);
    rchk(IORB_OTP_BASE + 24'h0000fc, 24'h00a5c3, "store word 63");
    wr(IORB_OTP_BASE, 24'h654321);
    rchk(IORB_OTP_BASE, 24'h123456, "store rewrite");
    @(posedge clk);
    otp_erase <= 1'b1;
    repeat (4) @(posedge clk);
    otp_erase <= 1'b0;
    rchk(IORB_OTP_BASE, 24'h123456, "store after erase");
    rchk(IORB_OTP_BASE + 24'h0000fc, 24'h00a5c3, "last word after erase");
    // the two mask settings must disagree on the pending events
    wr(IORB_OFF_IMASK, 24'h000000);
    repeat (2) @(posedge clk);
    #1 b0 = irq;
    wr(IORB_OFF_IMASK, 24'h000007);
    repeat (2) @(posedge clk);
    #1 chk("irq mask effect", 24'h000001, {23'h0, irq ^ b0});
    if (b0 === 1'b1) begin
      wr(IORB_OFF_IMASK, 24'h000000);
      repeat (2) @(posedge clk);
    end
    #1 chk("irq raised", 24'h000001, {23'h0, irq});
    rd(IORB_OFF_ISTAT, d);
    chk("status events", 24'h000006, d & 24'h000006);
    repeat (2) @(posedge clk);
    #1 chk("irq after clear", 24'h000000, {23'h0, irq});
    $display("test store and interrupt done");
    // brown-out with oscillator, pll and crystal all configured
    @(posedge clk);
    brownout_pin <= 1'b1;
    wait_sig(1'b0, 1'b0, 8, n);
    chk("reset asserted", 24'h000000, {23'h0, dev_reset_n});
    chk("clock withheld", 24'h000001, {23'h0, sysclk_hold});
    repeat (10) @(posedge clk);
    #1 chk("reset while brown-out", 24'h000000, {23'h0, dev_reset_n});
    @(posedge clk);
    brownout_pin <= 1'b0;
    repeat (20) @(posedge clk);
    // without lock the sequencer keeps both the clock and the reset back
    #1 chk("clock held without lock", 24'h000001, {23'h0, sysclk_hold});
    chk("reset held without lock", 24'h000000, {23'h0, dev_reset_n});
    @(posedge clk);
    pll_lock_pin <= 1'b1;
    wait_sig(1'b1, 1'b0, 20, n);
    chk("clock released", 24'h000000, {23'h0, sysclk_hold});
    wait_sig(1'b0, 1'b1, 4, n);
    chk("reset released", 24'h000001, {23'h0, dev_reset_n});
    rd(IORB_OFF_RESET_CONTROL_REGISTER, d);
    chk("brown-out flag", 24'h000002, d & 24'h000002);
    rd(IORB_OFF_ISTAT, d);
    chk("brown-out event", 24'h000001, d & 24'h000001);
    // second brown-out with lock present: the power-up count, longer than the start-up count, gates release
    @(posedge clk);
    brownout_pin <= 1'b1;
    wait_sig(1'b0, 1'b0, 8, n);
    @(posedge clk);
    brownout_pin <= 1'b0;
    wait_sig(1'b0, 1'b1, 100, n);
    chk("power-up delay applied", 24'h000001, {23'h0, n >= POWER_UP_TIMER + 2});
    $display("test brown-out done");
    stop_test();
  end
endmodule // tb
